// file: core/srxb_top.sv
// serial receiver status flags, data register and baud generator
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
// Behaviour
// - low stop bit sets framing flag, irq
// - status-one read then data read clears framing
// - parity mismatch sets parity flag, irq
// - status-one then data read clears parity
// - status two: zeros, break, active bits
// - break sets break, framing, full; clears ninth
// - break flag no irq; status-two/data clear
// - break rearms only after line high
// - low at first slot sets active flag
// - false start or idle clears active
// - prescaler select decodes 1,3,4,13
// - rate select decodes two to power
// - bit rate clock over 64*pd*bd
// - status-one then data read clears full
// - clear only flags seen at status read
module srxb_top
    import srxb_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // serial line
    input  wire logic       serial_input_pin,
    // transmit side
    output logic      [7:0] tx_data,
    output logic            tx_load,
    // interrupt
    output logic            irq
);
    typedef enum logic [2:0] {
        SRXB_IDLE  = 3'b000,
        SRXB_START = 3'b001,
        SRXB_DATA  = 3'b011,
        SRXB_STOP  = 3'b010
    } srxb_state_t;

    //////////////////////////////////////////////////////////////////////////
    // input synchroniser, three stages
    logic [2:0] sync;
    logic       line;            // filtered line level
    logic       next_line;
    always_comb begin
        next_line = (sync[1] == sync[2]) ? sync[2] : line;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync <= 3'h7;
            line <= 1'b1;
        end else begin
            sync <= {sync[1:0], serial_input_pin};
            line <= next_line;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0]  bit_rate_select;    // prescale in 5:4, rate in 2:0
    logic [7:0]  control_three;      // enables and ninth bit
    logic [7:0]  serial_data_buffer; // received byte, unaffected by reset
    logic [7:0]  irq_status, irq_enable;
    logic        framing_error_flag, parity_error_flag, receiver_full_flag;
    logic        break_flag, reception_active_flag, break_armed;
    logic [2:0]  seen_one;           // flags captured at status-one read
    logic        seen_two;           // break captured at status-two read
    srxb_state_t state;
    logic [3:0]  slot;               // sample slot within a bit
    logic [3:0]  bit_idx;            // data bit number
    logic [8:0]  shift;              // receive shift register
    logic [3:0]  idle_cnt;           // consecutive high bits
    logic        par_acc;            // running parity

    logic        sample_tick;
    srxb_rate_gen u_rate (
        .clock        (clock),
        .resetn       (resetn),
        .prescale_sel (bit_rate_select[BR_PS_LSB +: 2]),
        .rate_sel     (bit_rate_select[BR_RS_LSB +: 3]),
        .sample_tick  (sample_tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // receive engine next-state
    srxb_state_t next_state;
    logic [3:0]  next_slot, next_bit_idx, next_idle_cnt;
    logic [8:0]  next_shift;
    logic        next_par_acc;
    logic        ev_char, ev_break, ev_frame, ev_parity, ev_false, ev_idle, ev_start;
    logic [3:0]  nbits;
    logic        sample_point;
    always_comb begin
        next_state    = state;
        next_slot     = slot;
        next_bit_idx  = bit_idx;
        next_shift    = shift;
        next_par_acc  = par_acc;
        next_idle_cnt = idle_cnt;
        ev_char = 1'b0; ev_break = 1'b0; ev_frame = 1'b0;
        ev_parity = 1'b0; ev_false = 1'b0; ev_idle = 1'b0; ev_start = 1'b0;
        nbits = control_three[C_NINEBIT] ? 4'h9 : 4'h8;
        sample_point = (slot == 4'h8);
        if (sample_tick) begin
            next_slot = slot + 4'h1;
            case (state)
                SRXB_IDLE: begin
                    // slot runs free so whole idle bit times can be counted
                    if (!line) begin           // low at first slot
                        ev_start   = 1'b1;
                        next_slot  = 4'h1;
                        next_state = SRXB_START;
                    end
                end
                SRXB_START: begin
                    if (sample_point && line) begin
                        ev_false   = 1'b1;
                        next_state = SRXB_IDLE;
                    end else if (slot == 4'hF) begin
                        next_state   = SRXB_DATA;
                        next_bit_idx = 4'h0;
                        next_par_acc = 1'b0;
                    end
                end
                SRXB_DATA: begin
                    if (sample_point) begin
                        next_shift   = {line, shift[8:1]};
                        next_par_acc = par_acc ^ line;
                    end
                    if (slot == 4'hF) begin
                        next_bit_idx = bit_idx + 4'h1;
                        if (bit_idx == nbits - 4'h1)
                            next_state = SRXB_STOP;
                    end
                end
                SRXB_STOP: begin
                    if (sample_point) begin
                        next_state = SRXB_IDLE;
                        ev_char    = 1'b1;
                        ev_frame   = !line;
                        // eight-bit mode leaves a stale bit in shift[0]
                        ev_break   = !line && break_armed && ((control_three[C_NINEBIT] ?
                                     shift : {shift[8:1], 1'b0}) == 9'h000);
                        ev_parity  = control_three[C_PAR_EN] &&
                                     (par_acc != control_three[C_PAR_ODD]);
                        next_idle_cnt = 4'h0;
                    end
                end
                default: next_state = SRXB_IDLE;
            endcase
            // idle character counted in whole bit times of high line
            if (state == SRXB_IDLE && slot == 4'hF) begin
                if (!line)
                    next_idle_cnt = 4'h0;
                else if (idle_cnt != 4'(IDLE_BITS))
                    next_idle_cnt = idle_cnt + 4'h1;
            end
            if (state == SRXB_IDLE && line && slot == 4'hF && idle_cnt == 4'(IDLE_BITS - 1))
                ev_idle = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state    <= SRXB_IDLE;
            slot     <= 4'h0;
            bit_idx  <= 4'h0;
            shift    <= 9'h000;
            par_acc  <= 1'b0;
            idle_cnt <= 4'h0;
        end else begin
            state    <= next_state;
            slot     <= next_slot;
            bit_idx  <= next_bit_idx;
            shift    <= next_shift;
            par_acc  <= next_par_acc;
            idle_cnt <= next_idle_cnt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // flags, registers and read data next values
    logic        rd_s1, rd_s2, rd_dat, clr_data;
    logic        next_fe, next_pe, next_rf, next_bk, next_ra, next_armed, next_irq;
    logic [2:0]  next_seen_one;
    logic        next_seen_two;
    logic [7:0]  next_brs, next_ctl, next_buf, next_irq_status, next_irq_enable;
    logic [7:0]  next_rdata, next_tx_data;
    logic        next_tx_load;
    logic [7:0]  ev_vec;
    always_comb begin
        rd_s1  = rd && addr == ADDR_STATUS_ONE;
        rd_s2  = rd && addr == ADDR_STATUS_TWO;
        rd_dat = rd && addr == ADDR_DATA;
        // clear only what the status read saw; new sets win
        next_fe = (framing_error_flag && !(rd_dat && seen_one[S1_FRAMING]))
                  || ev_frame || ev_break;
        next_pe = (parity_error_flag && !(rd_dat && seen_one[S1_PARITY]))
                  || ev_parity;
        next_rf = (receiver_full_flag && !(rd_dat && seen_one[2]))
                  || ev_char;
        next_bk = (break_flag && !(rd_dat && seen_two)) || ev_break;
        // break rearms after line high
        next_armed = ev_break ? 1'b0 : (line ? 1'b1 : break_armed);
        next_ra = ev_start ? 1'b1 : ((ev_false || ev_idle || ev_char) ? 1'b0
                  : reception_active_flag);
        next_seen_one = seen_one;
        if (rd_s1)
            next_seen_one = {receiver_full_flag, framing_error_flag, parity_error_flag};
        else if (rd_dat)
            next_seen_one = 3'h0;
        next_seen_two = rd_s2 ? break_flag : (rd_dat ? 1'b0 : seen_two);
        // received byte and ninth bit
        next_buf = serial_data_buffer;
        next_ctl = control_three;
        if (ev_char) begin
            next_buf = control_three[C_NINEBIT] ? shift[7:0] : shift[8:1];
            next_ctl[C_NINTH] = control_three[C_NINEBIT] ? (shift[8] && !ev_break)
                                : shift[8];
        end
        next_brs = bit_rate_select;
        next_irq_enable = irq_enable;
        next_tx_data = tx_data;
        next_tx_load = 1'b0;
        clr_data = 1'b0;
        if (wr) begin
            case (addr)
                ADDR_BIT_RATE:   next_brs = wdata & 8'h37;
                ADDR_CONTROL:    next_ctl = {next_ctl[C_NINTH], wdata[6:0]};
                ADDR_IRQ_ENABLE: next_irq_enable = wdata;
                ADDR_DATA: begin
                    next_tx_data = wdata;
                    next_tx_load = 1'b1;
                end
                ADDR_IRQ_CLEAR:  clr_data = 1'b1;
                default:         clr_data = 1'b0;
            endcase
        end
        ev_vec = ZERO8;
        ev_vec[EV_FRAMING] = ev_frame || ev_break;
        ev_vec[EV_PARITY]  = ev_parity;
        next_irq_status = (irq_status & ~(clr_data ? wdata : ZERO8)) | ev_vec;
        // error request from flags gated by enables; break and active never request
        next_irq = (next_fe && next_ctl[C_FE_IE]) || (next_pe && next_ctl[C_PE_IE])
                   || |(next_irq_status & next_irq_enable);
        next_rdata = ZERO8;
        if (rd) begin
            case (addr)
                ADDR_STATUS_ONE: next_rdata = {2'h0, receiver_full_flag, 3'h0,
                                               framing_error_flag, parity_error_flag};
                ADDR_STATUS_TWO: next_rdata = {6'h00, break_flag, reception_active_flag};
                ADDR_DATA:       next_rdata = serial_data_buffer;
                ADDR_BIT_RATE:   next_rdata = bit_rate_select;
                ADDR_CONTROL:    next_rdata = control_three;
                ADDR_IRQ_STATUS: next_rdata = irq_status;
                ADDR_IRQ_ENABLE: next_rdata = irq_enable;
                default:         next_rdata = ZERO8;
            endcase
        end
    end

    // received byte keeps its value through reset
    always_ff @(posedge clock) begin
        serial_data_buffer <= next_buf;
    end

    // register flags, control registers and outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            framing_error_flag    <= 1'b0;
            parity_error_flag     <= 1'b0;
            receiver_full_flag    <= 1'b0;
            break_flag            <= 1'b0;
            reception_active_flag <= 1'b0;
            break_armed           <= 1'b1;
            seen_one              <= 3'h0;
            seen_two              <= 1'b0;
            bit_rate_select       <= ZERO8;
            control_three         <= ZERO8;
            irq_status            <= ZERO8;
            irq_enable            <= ZERO8;
            rdata                 <= ZERO8;
            tx_data               <= ZERO8;
            tx_load               <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            framing_error_flag    <= next_fe;
            parity_error_flag     <= next_pe;
            receiver_full_flag    <= next_rf;
            break_flag            <= next_bk;
            reception_active_flag <= next_ra;
            break_armed           <= next_armed;
            seen_one              <= next_seen_one;
            seen_two              <= next_seen_two;
            bit_rate_select       <= next_brs;
            control_three         <= next_ctl;
            irq_status            <= next_irq_status;
            irq_enable            <= next_irq_enable;
            rdata                 <= next_rdata;
            tx_data               <= next_tx_data;
            tx_load               <= next_tx_load;
            irq                   <= next_irq;
        end
    end
endmodule

// file: core/srxb_pkg.sv
// package: register map, field positions and constants of the serial receive/baud block
package srxb_pkg;
    // register offsets (8-bit space)
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h3B; // receive_status_one
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h3C; // receive_status_two
    localparam logic [7:0] ADDR_DATA       = 8'h3D; // serial_data_buffer
    localparam logic [7:0] ADDR_BIT_RATE   = 8'h3E; // bit_rate_select
    localparam logic [7:0] ADDR_CONTROL    = 8'h3F; // control_three subset
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40; // sticky event status
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h41; // event enable
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h42; // write one to clear
    // status one bit positions
    localparam int S1_RXFULL  = 5;
    localparam int S1_FRAMING = 1;
    localparam int S1_PARITY  = 0;
    // status two bit positions
    localparam int S2_BREAK  = 1;
    localparam int S2_ACTIVE = 0;
    // control bit positions
    localparam int C_NINTH   = 7;
    localparam int C_NINEBIT = 4;
    localparam int C_PAR_EN  = 3;
    localparam int C_PAR_ODD = 2;
    localparam int C_FE_IE   = 1;
    localparam int C_PE_IE   = 0;
    // bit rate fields
    localparam int BR_PS_LSB = 4;
    localparam int BR_RS_LSB = 0;
    // irq event bit positions
    localparam int EV_FRAMING = 0;
    localparam int EV_PARITY  = 1;
    // divider figures
    localparam int BASE_DIV   = 64;
    localparam int OVERSAMPLE = 16;
    localparam int TICK_DIV   = BASE_DIV / OVERSAMPLE;
    localparam logic [3:0] PS_DIV_0 = 4'h1;
    localparam logic [3:0] PS_DIV_1 = 4'h3;
    localparam logic [3:0] PS_DIV_2 = 4'h4;
    localparam logic [3:0] PS_DIV_3 = 4'hD;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam int IDLE_BITS = 10;
endpackage

// file: core/srxb_rate_gen.sv
// bit rate generator: sixteen-times-bit-rate sample tick
`timescale 1ns/10ps
module srxb_rate_gen
    import srxb_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // selects
    input  wire logic [1:0] prescale_sel,
    input  wire logic [2:0] rate_sel,
    // tick out
    output logic            sample_tick
);
    logic [3:0]  prescale_divisor;  // decoded prescaler
    logic [7:0]  rate_divisor;      // decoded rate divisor
    logic [15:0] limit;             // cycles per sample tick
    logic [15:0] count;             // running count
    logic [15:0] next_count;
    logic        next_tick;

    // decode selects into divisors
    always_comb begin
        case (prescale_sel)
            2'h0:    prescale_divisor = PS_DIV_0;
            2'h1:    prescale_divisor = PS_DIV_1;
            2'h2:    prescale_divisor = PS_DIV_2;
            default: prescale_divisor = PS_DIV_3;
        endcase
        rate_divisor = 8'h01 << rate_sel;
        // 64*pd*bd per bit, sixteen ticks per bit
        limit = 16'(TICK_DIV * prescale_divisor * rate_divisor);
    end

    // next counter value
    always_comb begin
        if (count >= limit - 16'h0001) begin
            next_count = 16'h0000;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 16'h0001;
            next_tick  = 1'b0;
        end
    end

    // register counter
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count       <= 16'h0000;
            sample_tick <= 1'b0;
        end else begin
            count       <= next_count;
            sample_tick <= next_tick;
        end
    end
endmodule

// file: verif/srxb_line_model.sv
// partner: remote serial transmitter driving the receive line
`timescale 1ns/10ps
module srxb_line_model (
    // clock
    input  wire logic clock,
    // serial line, idle high
    output logic      line
);
    initial line = 1'b1; // idle level until a frame starts
    ////////////////////////////////////////////////////////////////
    // hold the line at a level, for start-bit probing
    task set_line(input logic v);
        @(posedge clock);
        line <= v;
    endtask
    // frame: start, nbits lsb first, stop level, then two idle bit times
    task send(input logic [8:0] bits, input int nbits, input logic stop, input int period);
        @(posedge clock);
        line <= 1'b0;
        repeat (period) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            line <= bits[i];
            repeat (period) @(posedge clock); // same bit time both ways
        end
        line <= stop;
        repeat (period) @(posedge clock);
        line <= 1'b1; // line back high rearms break detection
        repeat (2 * period) @(posedge clock);
    endtask
endmodule

// file: verif/srxb_top_sva.sv
// checker: port-level properties of the serial receive/baud block
`timescale 1ns/10ps
module srxb_top_sva
    import srxb_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // line, transmit side, interrupt
    input wire logic       serial_input_pin,
    input wire logic [7:0] tx_data,
    input wire logic       tx_load,
    input wire logic       irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    logic [1:0] ie_ctl;      // shadow of error irq enables
    logic [7:0] ie_ev;       // shadow of event enables
    logic [1:0] next_ie_ctl;
    logic [7:0] next_ie_ev;
    // shadow the enable writes
    always_comb begin
        next_ie_ctl = ie_ctl;
        next_ie_ev  = ie_ev;
        if (wr && addr == ADDR_CONTROL) begin
            next_ie_ctl = wdata[1:0];
        end
        if (wr && addr == ADDR_IRQ_ENABLE) begin
            next_ie_ev = wdata;
        end
    end
    // register the shadows
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ie_ctl <= 2'h0;
            ie_ev  <= 8'h00;
        end else begin
            ie_ctl <= next_ie_ctl;
            ie_ev  <= next_ie_ev;
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !rd |=> rdata == ZERO8;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_status_two_zero;
        rd && addr == ADDR_STATUS_TWO |=> rdata[7:2] == 6'h00;
    endproperty
    a_status_two_zero: assert property (p_status_two_zero) else $error("status two upper bits");
    property p_unmapped;
        rd && (addr < ADDR_STATUS_ONE || addr > ADDR_IRQ_CLEAR) |=> rdata == ZERO8;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_tx_load;
        wr && addr == ADDR_DATA |=> tx_load && tx_data == $past(wdata);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("transmit byte not loaded");
    property p_no_tx_load;
        !(wr && addr == ADDR_DATA) |=> !tx_load;
    endproperty
    a_no_tx_load: assert property (p_no_tx_load) else $error("stray transmit load");
    property p_tx_hold;
        !wr |=> $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit byte moved");
    // a write in the same cycle may raise an enable, so only cycles without a write count
    property p_irq_masked;
        !wr && ie_ctl == 2'h0 && ie_ev == 8'h00 |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all enables off");
    property p_irq_hold;
        irq && !rd && !wr && !$past(rd) && !$past(wr) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");
    // main scenarios
    c_irq: cover property ($rose(irq));
    c_tx: cover property (tx_load);
    c_break: cover property (rd && addr == ADDR_STATUS_TWO ##1 rdata[S2_BREAK]);
endmodule
bind srxb_top srxb_top_sva srxb_top_sva_i (.clock(clock), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_input_pin(serial_input_pin),
    .tx_data(tx_data), .tx_load(tx_load), .irq(irq));

// file: verif/tb_top.sv
// testbench: register-level tests of the serial receive/baud block
`timescale 1ns/10ps
module tb_top
    import srxb_pkg::*;
;
    logic       clock;
    logic       resetn;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    wire  [7:0] rdata;
    wire        serial_line;  // driven by the line model
    wire  [7:0] tx_data;
    wire        tx_load;
    wire        irq;
    int         errors;
    int         n_checks;
    int         cycles;       // timeout counter
    logic [7:0] v;
    logic [7:0] b;
    int         period;
    int         ps_tab[7] = '{0, 1, 2, 3, 0, 0, 0};
    int         rs_tab[7] = '{0, 0, 0, 0, 1, 2, 3};
    int         pd_of[4]  = '{1, 3, 4, 13};
    ////////////////////////////////////////////////////////////////
    srxb_top srxb_top_i (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .serial_input_pin(serial_line),
        .tx_data(tx_data), .tx_load(tx_load), .irq(irq));
    srxb_line_model srxb_line_model_i (.clock(clock), .line(serial_line));
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            complete_run;
        end
    end
    ////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
    task check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task check1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask
    // read, mask and compare
    task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_reg(a, v);
        check8(nm, e, v & m);
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        resetn   = 1'b0;
        addr     = 8'h00;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        errors   = 0;
        n_checks = 0;
        cycles   = 0;
        tick(6);
        resetn <= 1'b1;
        // reset values and read-only space
        rd_chk("status one", ADDR_STATUS_ONE, 8'hFF, 8'h00);
        rd_chk("status two", ADDR_STATUS_TWO, 8'hFF, 8'h00);
        rd_chk("bit rate", ADDR_BIT_RATE, 8'hFF, 8'h00);
        wr_reg(ADDR_STATUS_TWO, 8'hFF);
        rd_chk("status two ro", ADDR_STATUS_TWO, 8'hFF, 8'h00);
        rd_chk("unmapped", 8'h10, 8'hFF, 8'h00);
        // every prescaler code and several rate codes carry a byte
        for (int i = 0; i < 7; i++) begin
            period = 64 * pd_of[ps_tab[i]] * (1 << rs_tab[i]);
            b = 8'h5A + 8'(i);
            wr_reg(ADDR_BIT_RATE, {2'b00, 2'(ps_tab[i]), 1'b0, 3'(rs_tab[i])});
            rd_chk("rate sel", ADDR_BIT_RATE, 8'h37,
                   {2'b00, 2'(ps_tab[i]), 1'b0, 3'(rs_tab[i])});
            srxb_line_model_i.send({1'b0, b}, 8, 1'b1, period);
            rd_chk("full set", ADDR_STATUS_ONE, 8'h23, 8'h20);
            rd_chk("rx byte", ADDR_DATA, 8'hFF, b);
            rd_chk("full clr", ADDR_STATUS_ONE, 8'h23, 8'h00);
        end
        wr_reg(ADDR_BIT_RATE, 8'h00);
        // framing error set between the two reads survives
        rd_chk("pre read", ADDR_STATUS_ONE, 8'h03, 8'h00);
        srxb_line_model_i.send(9'h081, 8, 1'b0, 64);
        rd_chk("bad stop byte", ADDR_DATA, 8'hFF, 8'h81);
        rd_chk("framing kept", ADDR_STATUS_ONE, 8'h03, 8'h02);
        wr_reg(ADDR_CONTROL, 8'h02);
        tick(2);
        check1("framing irq", 1'b1, irq);
        wr_reg(ADDR_IRQ_ENABLE, 8'h01);
        rd_reg(ADDR_STATUS_ONE, v);
        rd_reg(ADDR_DATA, v);
        rd_chk("framing clr", ADDR_STATUS_ONE, 8'h03, 8'h00);
        check1("event irq", 1'b1, irq);
        wr_reg(ADDR_IRQ_ENABLE, 8'h00);
        wr_reg(ADDR_CONTROL, 8'h00);
        tick(2);
        check1("masked irq", 1'b0, irq);
        wr_reg(ADDR_IRQ_CLEAR, 8'hFF);
        rd_chk("event clr", ADDR_IRQ_STATUS, 8'hFF, 8'h00);
        // nine-bit frame, parity mismatch with even parity selected
        wr_reg(ADDR_CONTROL, 8'h19);
        srxb_line_model_i.send({1'b0, 8'h13}, 9, 1'b1, 64);
        check1("parity irq", 1'b1, irq);
        rd_chk("parity set", ADDR_STATUS_ONE, 8'h03, 8'h01);
        rd_reg(ADDR_DATA, v);
        rd_chk("parity clr", ADDR_STATUS_ONE, 8'h03, 8'h00);
        check1("parity irq off", 1'b0, irq);
        // break in nine-bit mode, no enables
        wr_reg(ADDR_CONTROL, 8'h10);
        srxb_line_model_i.send({1'b1, 8'h3C}, 9, 1'b1, 64);
        rd_chk("ninth set", ADDR_CONTROL, 8'h80, 8'h80);
        srxb_line_model_i.send(9'h000, 9, 1'b0, 64);
        rd_chk("ninth clr", ADDR_CONTROL, 8'h80, 8'h00);
        rd_chk("break set", ADDR_STATUS_TWO, 8'h02, 8'h02);
        rd_chk("break side", ADDR_STATUS_ONE, 8'h23, 8'h22);
        check1("break irq", 1'b0, irq);
        rd_chk("break byte", ADDR_DATA, 8'hFF, 8'h00);
        rd_chk("break clr", ADDR_STATUS_TWO, 8'h02, 8'h00);
        rd_reg(ADDR_STATUS_ONE, v);
        rd_reg(ADDR_DATA, v);
        // transmit byte kept apart from received byte; load pulse stands one cycle
        wr_reg(ADDR_DATA, 8'hA5);
        @(negedge clock);
        check1("tx load", 1'b1, tx_load);
        check8("tx byte", 8'hA5, tx_data);
        rd_chk("rx kept", ADDR_DATA, 8'hFF, 8'h00);
        // short low pulse: reception flag rises then falls, polled as software would
        srxb_line_model_i.set_line(1'b0);
        tick(24);
        rd_chk("active set", ADDR_STATUS_TWO, 8'h01, 8'h01);
        srxb_line_model_i.set_line(1'b1);
        tick(80);
        rd_chk("active clr", ADDR_STATUS_TWO, 8'h01, 8'h00);
        complete_run;
    end
endmodule
